/* hw/disk_cmd_params.svh */
`ifndef DISK_CMD_PARAMS_SVH
`define DISK_CMD_PARAMS_SVH
// ----------------------------------------
// register indexes on the plain port
// ----------------------------------------
`define REG_DATA     4'h0
`define REG_ERROR    4'h1
`define REG_COUNT    4'h2
`define REG_LOW      4'h3
`define REG_MID      4'h4
`define REG_HIGH     4'h5
`define REG_DEVICE   4'h6
`define REG_CMD      4'h7
`define REG_INT_STAT 4'h8
`define REG_INT_MASK 4'h9
// ----------------------------------------
// command codes
// ----------------------------------------
`define CMD_WR_BUF   8'hE8
`define CMD_RD_BUF   8'hE4
`define CMD_WR_DMA   8'hCA
`define CMD_RETRY_MASK 8'hFE
// ----------------------------------------
// field positions and sizes
// ----------------------------------------
`define ST_BSY       7
`define ST_RDY       6
`define ST_DSC       4
`define ST_DRQ       3
`define ST_ERR       0
`define ER_UNC       6
`define ER_ABT       2
`define DEV_LBA      6
`define INT_DONE     0
`define INT_FAIL     1
`define SECTOR_WORDS 9'h100
`define COUNT_ZERO_SECTORS 9'h100
`define LAST_WORD    8'hFF
`endif

/* hw/disk_cmd_pkg.sv */
`default_nettype none
package disk_cmd_pkg;
	// sector address: read as chs or as a 28-bit block address
	typedef struct packed {
		logic [3:0] head;
		logic [7:0] high;
		logic [7:0] mid;
		logic [7:0] low;
	} addr_t;
	// one-hot command states
	typedef enum logic [4:0] {
		S_IDLE   = 5'h01,
		S_PIO_WR = 5'h02,
		S_PIO_RD = 5'h04,
		S_DMA    = 5'h08,
		S_MEDIA  = 5'h10
	} state_t;
endpackage
`default_nettype wire

/* hw/sector_buffer.sv */
`default_nettype none
module sector_buffer #(
	parameter int WORDS = 256,
	parameter int AW    = 8,
	parameter int DW    = 16
) (
	// clock
	input  wire logic          clock,
	// fill port
	input  wire logic          wr_en,
	input  wire logic [AW-1:0] wr_addr,
	input  wire logic [DW-1:0] wr_data,
	// host read port, combinational
	input  wire logic [AW-1:0] host_addr,
	output logic      [DW-1:0] host_data,
	// media read port, one cycle late
	input  wire logic [AW-1:0] media_addr,
	output logic      [DW-1:0] media_data
);
	logic [DW-1:0] mem [WORDS];

	// storage write
	always_ff @(posedge clock) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	// registered media read
	always_ff @(posedge clock) begin
		media_data <= mem[media_addr];
	end

	assign host_data = mem[host_addr];
endmodule
`default_nettype wire

/* hw/address_stepper.sv */
`default_nettype none
module address_stepper #(
	parameter int SPT   = 63,
	parameter int HEADS = 16
) (
	// current address and mode
	input  wire logic                 lba_mode,
	input  wire disk_cmd_pkg::addr_t  cur,
	// following sector
	output disk_cmd_pkg::addr_t       nxt
);
	localparam logic [7:0] LAST_SEC  = 8'(SPT);
	localparam logic [3:0] LAST_HEAD = 4'(HEADS - 1);

	// block mode counts straight, chs walks sector, head, cylinder
	always_comb begin
		nxt = cur;
		if (lba_mode) begin
			nxt = disk_cmd_pkg::addr_t'(28'(cur + 28'h0000001));
		end else if (cur.low != LAST_SEC) begin
			nxt.low = 8'(cur.low + 8'h01);
		end else begin
			nxt.low = 8'h01;
			if (cur.head != LAST_HEAD) begin
				nxt.head = 4'(cur.head + 4'h1);
			end else begin
				nxt.head = 4'h0;
				{nxt.high, nxt.mid} = 16'({cur.high, cur.mid} + 16'h0001);
			end
		end
	end
endmodule
`default_nettype wire

/* hw/disk_write_cmd.sv */
// Implementation choices: the placing of the registers and the address-and-strobe port.
`include "disk_cmd_params.svh"
`default_nettype none
// Summary of operation
// - Command E8h takes exactly one sector from the host into the sector buffer and never touches the media.
// - Sector data of E8h crosses the data register and that of the DMA write the dma data lines, as one 16-bit word per transfer.
// - Buffer write and buffer read use one shared pointer, so a read after a write returns the same 512 bytes.
// - Command CAh or CBh takes one or more sectors from the host and commits each to the media.
// - The retry bit in the low opcode bit is ignored, so both DMA write codes act the same.
// - Each DMA word is paced by the device raising its DMA request and moved by the host DMA channel.
// - One interrupt per DMA write, raised only once transfer has ended and final status is valid.
// - An uncorrectable error stops the DMA write at the failing sector with no further sectors moved.
// - A sector count of zero asks for 256 sectors.
// - With the mode flag set the start address is a 28-bit block address from low, mid, high and head.
// - With the mode flag clear low is the sector, mid and high the cylinder, head field the head.
// - At completion the count register holds the sectors not transferred, zero unless an error ended it.
// - At completion the address registers hold the address of the last sector handled, in the mode used.
module disk_write_cmd #(
	parameter int SPT   = 63,
	parameter int HEADS = 16
) (
	// clock and reset
	input  wire logic                 clock,
	input  wire logic                 nrst,
	// register port
	input  wire logic [3:0]           reg_addr,
	input  wire logic [15:0]          reg_wdata,
	input  wire logic                 reg_wr,
	input  wire logic                 reg_rd,
	output logic      [15:0]          reg_rdata,
	// slave dma
	output logic                      dmarq,
	input  wire logic                 dma_ack,
	input  wire logic [15:0]          dma_wdata,
	// media commit
	output logic                      media_req,
	output disk_cmd_pkg::addr_t       media_addr,
	input  wire logic                 media_done,
	input  wire logic                 media_uncorrectable,
	input  wire logic [7:0]           media_buf_addr,
	output logic      [15:0]          media_buf_data,
	// interrupt
	output logic                      irq
);
	disk_cmd_pkg::state_t state_ff;
	disk_cmd_pkg::state_t nxt_state;
	disk_cmd_pkg::addr_t  tf_addr_ff;
	disk_cmd_pkg::addr_t  work_addr_ff;
	disk_cmd_pkg::addr_t  next_addr;
	logic [7:0]  count_ff;
	logic [7:0]  dev_ff;
	logic [8:0]  remain_ff;
	logic [7:0]  ptr_ff;
	logic [7:0]  error_ff;
	logic        err_bit_ff;
	logic [1:0]  int_stat_ff;
	logic [1:0]  int_mask_ff;
	logic [1:0]  nxt_int_stat;
	logic [15:0] host_word;
	logic [15:0] buf_wdata;
	logic [7:0]  status;
	logic        lba_mode;
	logic        idle;
	logic        cmd_wr;
	logic        go_wr_buf;
	logic        go_rd_buf;
	logic        go_dma;
	logic        go_abort;
	logic        pio_word;
	logic        pio_rd_word;
	logic        dma_word;
	logic        last_word;
	logic        media_ok;
	logic        media_bad;
	logic        dma_end;
	logic        buf_end;
	logic        buf_we;

	// ----------------------------------------
	// decode
	// ----------------------------------------
	assign idle     = (state_ff == disk_cmd_pkg::S_IDLE);
	assign lba_mode = dev_ff[`DEV_LBA];
	assign cmd_wr   = reg_wr && (reg_addr == `REG_CMD) && idle;
	// opcode compare, with the retry bit masked off for the dma write only
	assign go_wr_buf = cmd_wr && (reg_wdata[7:0] == `CMD_WR_BUF);
	assign go_rd_buf = cmd_wr && (reg_wdata[7:0] == `CMD_RD_BUF);
	assign go_dma    = cmd_wr && ((reg_wdata[7:0] & `CMD_RETRY_MASK) == `CMD_WR_DMA);
	assign go_abort  = cmd_wr && !go_wr_buf && !go_rd_buf && !go_dma;
	// word events on the data register and the dma channel
	assign pio_word    = reg_wr && (reg_addr == `REG_DATA) && (state_ff == disk_cmd_pkg::S_PIO_WR);
	assign pio_rd_word = reg_rd && (reg_addr == `REG_DATA) && (state_ff == disk_cmd_pkg::S_PIO_RD);
	assign dma_word    = dmarq && dma_ack && (state_ff == disk_cmd_pkg::S_DMA);
	assign last_word   = (ptr_ff == `LAST_WORD);
	assign media_ok    = (state_ff == disk_cmd_pkg::S_MEDIA) && media_done && !media_uncorrectable;
	assign media_bad   = (state_ff == disk_cmd_pkg::S_MEDIA) && media_done && media_uncorrectable;
	assign dma_end     = media_bad || (media_ok && (remain_ff == 9'h001));
	assign buf_end     = (pio_word || pio_rd_word) && last_word;
	assign buf_we      = pio_word || dma_word;
	assign buf_wdata   = pio_word ? reg_wdata : dma_wdata;

	// ----------------------------------------
	// sub blocks
	// ----------------------------------------
	sector_buffer #(
		.WORDS (256),
		.AW    (8),
		.DW    (16)
	) u_buf (
		.clock      (clock),
		.wr_en      (buf_we),
		.wr_addr    (ptr_ff),
		.wr_data    (buf_wdata),
		.host_addr  (ptr_ff),
		.host_data  (host_word),
		.media_addr (media_buf_addr),
		.media_data (media_buf_data)
	);

	address_stepper #(
		.SPT   (SPT),
		.HEADS (HEADS)
	) u_step (
		.lba_mode (lba_mode),
		.cur      (work_addr_ff),
		.nxt      (next_addr)
	);

	// ----------------------------------------
	// command sequencer
	// ----------------------------------------
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			disk_cmd_pkg::S_IDLE: begin
				if (go_wr_buf) begin
					nxt_state = disk_cmd_pkg::S_PIO_WR;
				end else if (go_rd_buf) begin
					nxt_state = disk_cmd_pkg::S_PIO_RD;
				end else if (go_dma) begin
					nxt_state = disk_cmd_pkg::S_DMA;
				end
			end
			disk_cmd_pkg::S_PIO_WR,
			disk_cmd_pkg::S_PIO_RD: begin
				if (buf_end) begin
					nxt_state = disk_cmd_pkg::S_IDLE;
				end
			end
			disk_cmd_pkg::S_DMA: begin
				if (dma_word && last_word) begin
					nxt_state = disk_cmd_pkg::S_MEDIA;
				end
			end
			disk_cmd_pkg::S_MEDIA: begin
				if (dma_end) begin
					nxt_state = disk_cmd_pkg::S_IDLE;
				end else if (media_ok) begin
					nxt_state = disk_cmd_pkg::S_DMA;
				end
			end
			default: nxt_state = disk_cmd_pkg::S_IDLE;
		endcase
	end

	// state register
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			state_ff <= disk_cmd_pkg::S_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// shared buffer word pointer
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			ptr_ff <= 8'h00;
		end else if (go_wr_buf || go_rd_buf || go_dma) begin
			ptr_ff <= 8'h00;
		end else if (pio_word || pio_rd_word || dma_word) begin
			ptr_ff <= 8'(ptr_ff + 8'h01);
		end
	end

	// dma request, dropped with the last word of a sector
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			dmarq <= 1'b0;
		end else begin
			dmarq <= (nxt_state == disk_cmd_pkg::S_DMA) && !(dma_word && last_word);
		end
	end

	// ----------------------------------------
	// address and count
	// ----------------------------------------
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			work_addr_ff <= '0;
			remain_ff    <= 9'h000;
		end else if (go_dma) begin
			work_addr_ff <= {dev_ff[3:0], tf_addr_ff.high, tf_addr_ff.mid, tf_addr_ff.low};
			remain_ff    <= (count_ff == 8'h00) ? `COUNT_ZERO_SECTORS : {1'b0, count_ff};
		end else if (media_ok && !dma_end) begin
			work_addr_ff <= next_addr;
			remain_ff    <= 9'(remain_ff - 9'h001);
		end
	end

	// media commit request per filled sector
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			media_req  <= 1'b0;
			media_addr <= '0;
		end else begin
			media_req  <= dma_word && last_word;
			media_addr <= work_addr_ff;
		end
	end

	// task file, host writes only while idle, written back at dma end
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			tf_addr_ff <= '0;
			count_ff   <= 8'h00;
			dev_ff     <= 8'h00;
		end else if (dma_end) begin
			count_ff        <= media_bad ? remain_ff[7:0] : 8'h00;
			tf_addr_ff.low  <= work_addr_ff.low;
			tf_addr_ff.mid  <= work_addr_ff.mid;
			tf_addr_ff.high <= work_addr_ff.high;
			dev_ff[3:0]     <= work_addr_ff.head;
		end else if (reg_wr && idle) begin
			case (reg_addr)
				`REG_COUNT:  count_ff        <= reg_wdata[7:0];
				`REG_LOW:    tf_addr_ff.low  <= reg_wdata[7:0];
				`REG_MID:    tf_addr_ff.mid  <= reg_wdata[7:0];
				`REG_HIGH:   tf_addr_ff.high <= reg_wdata[7:0];
				`REG_DEVICE: dev_ff          <= reg_wdata[7:0];
				default: ;
			endcase
		end
	end

	// ----------------------------------------
	// error and status
	// ----------------------------------------
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			error_ff   <= 8'h00;
			err_bit_ff <= 1'b0;
		end else if (cmd_wr) begin
			error_ff             <= 8'h00;
			error_ff[`ER_ABT]    <= go_abort;
			err_bit_ff           <= go_abort;
		end else if (media_bad) begin
			error_ff[`ER_UNC]    <= 1'b1;
			err_bit_ff           <= 1'b1;
		end
	end

	// busy during dma write and media commit, drq during buffer transfers, ready always valid
	always_comb begin
		status              = 8'h00;
		status[`ST_BSY]     = !idle && (state_ff != disk_cmd_pkg::S_PIO_WR) && (state_ff != disk_cmd_pkg::S_PIO_RD);
		status[`ST_RDY]     = 1'b1;
		status[`ST_DSC]     = 1'b1;
		status[`ST_DRQ]     = (state_ff == disk_cmd_pkg::S_PIO_WR) || (state_ff == disk_cmd_pkg::S_PIO_RD);
		status[`ST_ERR]     = err_bit_ff;
	end

	// ----------------------------------------
	// interrupt
	// ----------------------------------------
	// set wins over a write-one clear in the same cycle
	always_comb begin
		nxt_int_stat = int_stat_ff;
		if (reg_wr && (reg_addr == `REG_INT_STAT)) begin
			nxt_int_stat = int_stat_ff & ~reg_wdata[1:0];
		end
		if (dma_end || buf_end || go_abort) begin
			nxt_int_stat[`INT_DONE] = 1'b1;
		end
		if (media_bad || go_abort) begin
			nxt_int_stat[`INT_FAIL] = 1'b1;
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			int_stat_ff <= 2'h0;
			int_mask_ff <= 2'h0;
			irq         <= 1'b0;
		end else begin
			int_stat_ff <= nxt_int_stat;
			if (reg_wr && (reg_addr == `REG_INT_MASK)) begin
				int_mask_ff <= reg_wdata[1:0];
			end
			irq <= |(nxt_int_stat & int_mask_ff);
		end
	end

	// ----------------------------------------
	// read data, one cycle after the strobe
	// ----------------------------------------
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			reg_rdata <= 16'h0000;
		end else if (reg_rd) begin
			case (reg_addr)
				`REG_DATA:     reg_rdata <= pio_rd_word ? host_word : 16'h0000;
				`REG_ERROR:    reg_rdata <= {8'h00, error_ff};
				`REG_COUNT:    reg_rdata <= {8'h00, count_ff};
				`REG_LOW:      reg_rdata <= {8'h00, tf_addr_ff.low};
				`REG_MID:      reg_rdata <= {8'h00, tf_addr_ff.mid};
				`REG_HIGH:     reg_rdata <= {8'h00, tf_addr_ff.high};
				`REG_DEVICE:   reg_rdata <= {8'h00, dev_ff};
				`REG_CMD:      reg_rdata <= {8'h00, status};
				`REG_INT_STAT: reg_rdata <= {14'h0000, int_stat_ff};
				`REG_INT_MASK: reg_rdata <= {14'h0000, int_mask_ff};
				default:       reg_rdata <= 16'h0000;
			endcase
		end else begin
			reg_rdata <= 16'h0000;
		end
	end
endmodule
`default_nettype wire

/* testbench/disk_write_cmd_assertions.sv */
`default_nettype none
module disk_write_cmd_checker #(
	parameter int SPT   = 63,
	parameter int HEADS = 16
) (
	// clock and reset
	input wire logic        clock,
	input wire logic        nrst,
	// register port
	input wire logic [3:0]  reg_addr,
	input wire logic        reg_rd,
	input wire logic [15:0] reg_rdata,
	// dma and media
	input wire logic        dmarq,
	input wire logic        dma_ack,
	input wire logic        media_req,
	input wire logic        media_done,
	input wire logic        media_uncorrectable,
	// interrupt
	input wire logic        irq
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [8:0] words_ff;
	// words taken in the current sector
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst)
			words_ff <= 9'h000;
		else
			words_ff <= dmarq ? words_ff + {8'h00, dma_ack} : 9'h000;
	end
	default clocking @(posedge clock); endclocking
	default disable iff (!nrst);
	AST_READY_SET: assert property ($past(reg_rd) && $past(reg_addr) == 4'h7 |-> reg_rdata[6])
		else $error("ready bit low in status");
	AST_BUSY_DMA: assert property (reg_rd && reg_addr == 4'h7 && dmarq |=> reg_rdata[7])
		else $error("busy low during dma");
	AST_WORD_COUNT: assert property ($fell(dmarq) |-> words_ff == 9'h100)
		else $error("sector ended with wrong word count");
	AST_NO_OVERRUN: assert property (dmarq |-> words_ff < 9'h100)
		else $error("request past a full sector");
	AST_COMMIT_AFTER: assert property ($fell(dmarq) |-> media_req)
		else $error("no commit after sector");
	AST_COMMIT_ORIGIN: assert property (media_req |-> $fell(dmarq) ##1 !media_req && !dmarq)
		else $error("commit pulse out of place");
	AST_UNC_STOP: assert property (media_done && media_uncorrectable |=> !dmarq [*4])
		else $error("transfer went on after failure");
	AST_IRQ_AFTER_END: assert property ($rose(irq) |-> !dmarq && !media_req)
		else $error("interrupt during transfer");
	AST_DMARQ_HOLD: assert property (dmarq && !dma_ack |=> dmarq)
		else $error("request dropped while waiting");
endmodule
bind disk_write_cmd disk_write_cmd_checker #(.SPT(SPT), .HEADS(HEADS)) u_checker (.clock, .nrst, .reg_addr,
	.reg_rd, .reg_rdata, .dmarq, .dma_ack, .media_req, .media_done, .media_uncorrectable, .irq);
`default_nettype wire

/* testbench/host_dma_model.sv */
`default_nettype none
module host_dma_model (
	// clock and reset
	input wire logic         clock,
	input wire logic         nrst,
	// pacing and data key
	input wire logic         stall,
	input wire logic [7:0]   key,
	// slave dma lines
	input wire logic         dmarq,
	output logic             dma_ack,
	output logic      [15:0] dma_wdata
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [8:0] widx_ff;
	logic       take;
	assign take = dma_ack && dmarq;
	// word index within the sector
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst)
			widx_ff <= 9'h000;
		else
			widx_ff <= dmarq ? widx_ff + {8'h00, take} : 9'h000;
	end
	// channel set up from reset, one word per cycle only while requested
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			dma_ack   <= 1'b0;
			dma_wdata <= 16'h0000;
		end else if (dmarq && !stall && (widx_ff + {8'h00, take}) < 9'h100) begin
			dma_ack   <= 1'b1;
			dma_wdata <= {key, widx_ff[7:0] + {7'h00, take}};
		end else begin
			dma_ack   <= 1'b0;
			dma_wdata <= ~dma_wdata; // released lines
		end
	end
endmodule
`default_nettype wire

/* testbench/test_disk_write_cmd.sv */
`default_nettype none
module test_disk_write_cmd;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, rd_pend = 1'b0, stall = 1'b0, stall_en = 1'b0;
	logic media_done = 1'b0, bad_sector = 1'b0, dmarq, dma_ack, media_req, irq;
	logic [3:0] reg_addr = 4'h0;
	logic [7:0] key = 8'h00, media_buf_addr = 8'h00;
	logic [15:0] reg_wdata = 16'h0000, reg_rdata, dma_wdata, media_buf_data, buf_words [256];
	logic [15:0] exp_q [$];
	disk_cmd_pkg::addr_t media_addr, start, exp_addr_q [$];
	int fails = 0, n_compared = 0, seed = 23, cyc = 0, n_commit = 0, fail_at = 0;
	always #25 clock = ~clock;
	disk_write_cmd dut (.clock, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .dmarq, .dma_ack,
		.dma_wdata, .media_req, .media_addr, .media_done, .media_uncorrectable(bad_sector), .media_buf_addr,
		.media_buf_data, .irq);
	host_dma_model host (.clock, .nrst, .stall, .key, .dmarq, .dma_ack, .dma_wdata);
	task automatic print_verdict;
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		reg_wr <= 1'b1;
		reg_rd <= 1'b0;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clock);
	endtask
	task automatic rd(input logic [3:0] a, input logic [15:0] e);
		exp_q.push_back(e);
		reg_rd <= 1'b1;
		reg_wr <= 1'b0;
		reg_addr <= a;
		@(posedge clock);
	endtask
	task automatic idle(input int n);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		repeat (n) @(posedge clock);
	endtask
	task automatic cmd(input logic [7:0] code, input logic [7:0] cnt, input logic lba, input disk_cmd_pkg::addr_t s);
		key <= 8'($random(seed));
		n_commit = 0;
		wr(4'h2, {8'h00, cnt});
		wr(4'h3, {8'h00, s.low});
		wr(4'h4, {8'h00, s.mid});
		wr(4'h5, {8'h00, s.high});
		wr(4'h6, {9'h000, lba, 2'b00, s.head});
		wr(4'h7, {8'h00, code});
		rd(4'h7, 16'h00D0);
		idle(1);
	endtask
	task automatic finish(input logic lba, input logic [7:0] left, input disk_cmd_pkg::addr_t last,
		input logic [7:0] err, input logic [1:0] ints);
		int i;
		for (i = 0; i < 70000 && irq !== 1'b1; i++)
			@(posedge clock);
		check(irq, 1'b1);
		rd(4'h2, {8'h00, left});
		rd(4'h3, {8'h00, last.low});
		rd(4'h4, {8'h00, last.mid});
		rd(4'h5, {8'h00, last.high});
		rd(4'h6, {9'h000, lba, 2'b00, last.head});
		rd(4'h1, {8'h00, err});
		rd(4'h7, {8'h00, 7'h28, err != 8'h00});
		rd(4'h8, {14'h0000, ints});
		wr(4'h8, 16'h0003);
		idle(2);
	endtask
	// compare each read answer against the oldest note
	always @(posedge clock) begin
		if (rd_pend)
			check(reg_rdata, exp_q.pop_front());
		rd_pend = reg_rd;
	end
	// cycle ceiling and host stalls
	always @(posedge clock) begin
		cyc++;
		stall <= stall_en && ($random(seed) & 3) == 0;
		if (cyc > 95000) begin
			fails++;
			print_verdict;
		end
	end
	// media side: check commit address and buffer, then answer
	always @(posedge clock) begin
		if (media_req) begin
			n_commit++;
			check(media_addr, exp_addr_q.pop_front());
			media_buf_addr <= 8'h00;
			@(posedge clock);
			media_buf_addr <= 8'hFF;
			@(posedge clock);
			check(media_buf_data, {key, 8'h00});
			@(posedge clock);
			check(media_buf_data, {key, 8'hFF});
			media_done <= 1'b1;
			bad_sector <= n_commit == fail_at;
			@(posedge clock);
			media_done <= 1'b0;
			bad_sector <= 1'b0;
		end
	end
	// main sequence
	initial begin
		idle(10);
		nrst <= 1'b1;
		idle(1);
		rd(4'h7, 16'h0050);
		rd(4'h9, 16'h0000);
		rd(4'hA, 16'h0000);
		wr(4'h9, 16'h0003);
		wr(4'h7, 16'h00E8);
		for (int i = 0; i < 256; i++) begin
			buf_words[i] = 16'($random(seed));
			wr(4'h0, buf_words[i]);
		end
		idle(2);
		rd(4'h8, 16'h0001);
		check(irq, 1'b1);
		wr(4'h9, 16'h0000);
		idle(2);
		check(irq, 1'b0);
		wr(4'h8, 16'h0001);
		wr(4'h9, 16'h0003);
		rd(4'h8, 16'h0000);
		wr(4'h7, 16'h00E4);
		for (int i = 0; i < 256; i++)
			rd(4'h0, buf_words[i]);
		idle(2);
		check(n_commit, 0);
		wr(4'h8, 16'h0003);
		stall_en = 1'b1;
		for (int c = 0; c < 2; c++) begin
			start = 28'($random(seed)) & 28'hFFFFFF0;
			exp_addr_q.push_back(start);
			exp_addr_q.push_back(start + 28'h1);
			cmd(8'hCA | 8'(c), 8'h02, 1'b1, start);
			finish(1'b1, 8'h00, start + 28'h1, 8'h00, 2'b01);
		end
		exp_addr_q.push_back(28'hF01233F);
		exp_addr_q.push_back(28'h0012401);
		cmd(8'hCA, 8'h02, 1'b0, 28'hF01233F);
		finish(1'b0, 8'h00, 28'h0012401, 8'h00, 2'b01);
		fail_at = 2;
		exp_addr_q.push_back(28'h0ABCDE0);
		exp_addr_q.push_back(28'h0ABCDE1);
		cmd(8'hCB, 8'h03, 1'b1, 28'h0ABCDE0);
		finish(1'b1, 8'h02, 28'h0ABCDE1, 8'h40, 2'b11);
		check(n_commit, 2);
		fail_at = 0;
		wr(4'h7, 16'h0055);
		idle(2);
		rd(4'h1, 16'h0004);
		rd(4'h7, 16'h0051);
		rd(4'h8, 16'h0003);
		wr(4'h8, 16'h0003);
		stall_en = 1'b0;
		for (int i = 0; i < 256; i++)
			exp_addr_q.push_back(28'h0000F00 + 28'(i));
		cmd(8'hCA, 8'h00, 1'b1, 28'h0000F00);
		finish(1'b1, 8'h00, 28'h0000FFF, 8'h00, 2'b01);
		check(n_commit, 256);
		idle(2);
		print_verdict;
	end
endmodule
`default_nettype wire
